// *** logic/rcf_pkg.sv ***
`default_nettype none

package rcf_pkg;

  typedef enum logic [1:0] {
    RCF_ECC_CLEAN  = 2'b00,
    RCF_ECC_SINGLE = 2'b01,
    RCF_ECC_DOUBLE = 2'b10
  } rcf_ecc_type;

endpackage : rcf_pkg

`default_nettype wire

// *** logic/rcf_read_fifo.sv ***
// What this block does
// - Almost-full flag high while stored count is at or above full threshold.
// - Almost-empty flag high while stored count is at or below empty threshold.
// - Thresholds are log2(depth) bits wide and are taken while reset is active.
// - Single-bit injection alone on a write stores the word with one flipped bit.
// - Double-bit injection on a write stores the word with two flipped bits.
// - Single-error output rises when a corrected one-bit error is read out.
// - Double-error output rises when an uncorrectable word is read out.
// - Overflow is tied low; m_axi_rready falls when full, so no write is refused.
// - Refused writes leave contents intact; overflow may stay low.
// - Underflow is tied low; s_axi_rvalid falls when empty, so no read is refused.
// - Reads are never permitted while empty, so underflow may stay low.
// - Write-side count never under-reports stored words.
// - Write-side count changes on the same edge that takes a write, with no lag.
// - Read-side count never over-reports readable words.
// - Read-side count changes on the same edge that takes a read, with no lag.
// - Common clock gives one occupancy count of stored words.
// - Read-side valid is high exactly when a buffered beat is available and clock enable is high.
// - Read-data width is 8, 16, 32, 64, 128, 256 or 512 bits.
`include "rcf_regs.svh"
`default_nettype none

module rcf_fifo
  import rcf_pkg::*;
#(
  parameter int WIDTH = `RCF_DEF_DATA_W,
  parameter int DEPTH = `RCF_DEF_DEPTH,
  parameter int AW = $clog2(DEPTH),
  parameter int LW = AW + 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  // Occupancy
  output logic [LW-1:0] level
);

  localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);
  localparam logic [LW-1:0] EMPTY_LVL = LW'(0);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [LW-1:0] level_ff;
  logic [LW-1:0] nxt_level;
  logic push;
  logic pop;

  // Clock enable low stalls both sides so no beat is taken while frozen
  assign in_ready = clk_en && (level_ff != FULL_LVL);
  assign out_valid = clk_en && (level_ff != EMPTY_LVL);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_ff];
  assign level = level_ff;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= `RCF_PTR_RST;
    end else if (push) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_ptr_ff <= `RCF_PTR_RST;
    end else if (pop) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

  always_comb begin
    nxt_level = level_ff;
    if (push && !pop) begin
      nxt_level = level_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_level = level_ff - 1'b1;
    end
  end

  // Count changes on the same edge that takes the beat, so it never lags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_ff <= `RCF_CNT_RST;
    end else begin
      level_ff <= nxt_level;
    end
  end

endmodule : rcf_fifo

module rcf_read_fifo
  import rcf_pkg::*;
#(
  parameter int DATA_W = `RCF_DEF_DATA_W,
  parameter int ID_W = `RCF_DEF_ID_W,
  parameter int USER_W = `RCF_DEF_USER_W,
  parameter int DEPTH = `RCF_DEF_DEPTH,
  parameter bit ECC_EN = 1'b1,
  parameter int TW = $clog2(DEPTH),
  parameter int CNT_W = TW + 2
) (
  // Clock, enable and reset
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic rst,
  // Read data from the slave (fill side)
  input wire logic [ID_W-1:0] m_axi_rid,
  input wire logic [DATA_W-1:0] m_axi_rdata,
  input wire logic [`RCF_RESP_W-1:0] m_axi_rresp,
  input wire logic m_axi_rlast,
  input wire logic [USER_W-1:0] m_axi_ruser,
  input wire logic m_axi_rvalid,
  output logic m_axi_rready,
  // Read data to the master (drain side)
  output logic [ID_W-1:0] s_axi_rid,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [`RCF_RESP_W-1:0] s_axi_rresp,
  output logic s_axi_rlast,
  output logic [USER_W-1:0] s_axi_ruser,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Thresholds
  input wire logic [TW-1:0] prog_full_thresh,
  input wire logic [TW-1:0] prog_empty_thresh,
  // Error injection and reporting
  input wire logic inject_sbit_err,
  input wire logic inject_dbit_err,
  output logic sbit_err,
  output logic dbit_err,
  // Status
  output logic overflow,
  output logic underflow,
  output logic [CNT_W-1:0] wr_data_count,
  output logic [CNT_W-1:0] rd_data_count,
  output logic [CNT_W-1:0] data_count,
  output logic prog_full,
  output logic prog_empty
);

  function automatic int rcf_par_bits(input int w);
    int p;
    p = 1;
    while ((1 << p) < (w + p + 1)) begin
      p++;
    end
    return p;
  endfunction : rcf_par_bits

  // Payload is {rid, rdata, rresp, rlast, ruser}; rdata width legal set is 8..512
  localparam int PW = ID_W + DATA_W + `RCF_RESP_W + 1 + USER_W;
  localparam int PB = rcf_par_bits(PW);
  localparam int CW = ECC_EN ? (PW + PB + 1) : PW;

  // Extended Hamming: bit 0 is overall parity, parity bits at powers of two
  function automatic logic [CW-1:0] rcf_encode(input logic [PW-1:0] d);
    logic [CW-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i < CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k++;
      end
    end
    for (int j = 0; j < PB; j++) begin
      for (int i = 1; i < CW; i++) begin
        if (((i >> j) & 1) == 1 && i != (1 << j)) begin
          c[1 << j] = c[1 << j] ^ c[i];
        end
      end
    end
    c[0] = ^c[CW-1:1];
    return c;
  endfunction : rcf_encode

  function automatic int rcf_syndrome(input logic [CW-1:0] c);
    int s;
    s = 0;
    for (int i = 1; i < CW; i++) begin
      if (c[i]) begin
        s = s ^ i;
      end
    end
    return s;
  endfunction : rcf_syndrome

  function automatic rcf_ecc_type rcf_status(input logic [CW-1:0] c);
    int s;
    rcf_ecc_type st;
    s = rcf_syndrome(c);
    st = RCF_ECC_CLEAN;
    if (^c) begin
      st = (s < CW) ? RCF_ECC_SINGLE : RCF_ECC_DOUBLE;
    end else if (s != 0) begin
      st = RCF_ECC_DOUBLE;
    end
    return st;
  endfunction : rcf_status

  function automatic logic [PW-1:0] rcf_decode(input logic [CW-1:0] c);
    logic [CW-1:0] f;
    logic [PW-1:0] d;
    int s;
    int k;
    f = c;
    d = '0;
    k = 0;
    s = rcf_syndrome(c);
    if (rcf_status(c) == RCF_ECC_SINGLE && s != 0) begin
      f[s] = ~f[s];
    end
    for (int i = 1; i < CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = f[i];
        k++;
      end
    end
    return d;
  endfunction : rcf_decode

  logic [PW-1:0] wr_payload;
  logic [PW-1:0] rd_payload;
  logic [CW-1:0] wr_word;
  logic [CW-1:0] rd_word;
  logic [CNT_W-1:0] level;
  logic [TW-1:0] full_thr_ff;
  logic [TW-1:0] empty_thr_ff;
  rcf_ecc_type rd_status;

  assign wr_payload = {m_axi_rid, m_axi_rdata, m_axi_rresp, m_axi_rlast, m_axi_ruser};

  generate
    if (ECC_EN) begin : g_ecc
      logic [CW-1:0] inj_mask;
      always_comb begin
        inj_mask = '0;
        if (inject_dbit_err) begin
          inj_mask[`RCF_INJ_BIT_A] = 1'b1;
          inj_mask[`RCF_INJ_BIT_B] = 1'b1;
        end else if (inject_sbit_err) begin
          inj_mask[`RCF_INJ_BIT_A] = 1'b1;
        end
      end
      assign wr_word = rcf_encode(wr_payload) ^ inj_mask;
      assign rd_payload = rcf_decode(rd_word);
      assign rd_status = rcf_status(rd_word);
    end else begin : g_plain
      assign wr_word = wr_payload;
      assign rd_payload = rd_word;
      assign rd_status = RCF_ECC_CLEAN;
    end
  endgenerate

  rcf_fifo #(
    .WIDTH(CW),
    .DEPTH(DEPTH),
    .AW(TW),
    .LW(CNT_W)
  ) rcf_fifo_inst (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .rst(rst),
    .in_valid(m_axi_rvalid),
    .in_ready(m_axi_rready),
    .in_data(wr_word),
    .out_ready(s_axi_rready),
    .out_valid(s_axi_rvalid),
    .out_data(rd_word),
    .level(level)
  );

  assign {s_axi_rid, s_axi_rdata, s_axi_rresp, s_axi_rlast, s_axi_ruser} = rd_payload;

  // Flags qualify the beat on offer, so they fall while reset empties the buffer
  assign sbit_err = s_axi_rvalid && (rd_status == RCF_ECC_SINGLE);
  assign dbit_err = s_axi_rvalid && (rd_status == RCF_ECC_DOUBLE);

  // Thresholds are sampled on every edge while reset is held, then kept
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      full_thr_ff <= prog_full_thresh;
      empty_thr_ff <= prog_empty_thresh;
    end
  end

  // One clock: the stored count is exact, so neither side can misreport
  assign data_count = level;
  assign wr_data_count = level;
  assign rd_data_count = level;
  assign prog_full = level >= CNT_W'(full_thr_ff);
  assign prog_empty = level <= CNT_W'(empty_thr_ff);

  // The handshake refuses nothing, so no refused request ever occurs
  assign overflow = `RCF_FLAG_RST;
  assign underflow = `RCF_FLAG_RST;

endmodule : rcf_read_fifo

`default_nettype wire

// *** logic/rcf_regs.svh ***
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH

// Reset values
`define RCF_CNT_RST '0
`define RCF_PTR_RST '0
`define RCF_FLAG_RST 1'b0

// Codeword bit positions flipped by the error injection inputs
`define RCF_INJ_BIT_A 3
`define RCF_INJ_BIT_B 5

// Default configuration
`define RCF_DEF_DEPTH 8
`define RCF_DEF_DATA_W 32
`define RCF_DEF_ID_W 4
`define RCF_DEF_USER_W 1
`define RCF_RESP_W 2

`endif

// *** verification/rcf_read_fifo_sva.sv ***
`default_nettype none
module rcf_chk #(
  parameter int DEPTH = 8,
  parameter int TW = 3,
  parameter int CNT_W = 5
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic rst,
  // Handshakes
  input wire logic m_axi_rvalid,
  input wire logic m_axi_rready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Thresholds and status
  input wire logic [TW-1:0] prog_full_thresh,
  input wire logic [TW-1:0] prog_empty_thresh,
  input wire logic sbit_err,
  input wire logic dbit_err,
  input wire logic overflow,
  input wire logic underflow,
  input wire logic [CNT_W-1:0] data_count,
  input wire logic prog_full,
  input wire logic prog_empty
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [TW-1:0] full_q;
  logic [TW-1:0] empty_q;
  // Thresholds count only as sampled while reset is held; later pin changes are ignored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      full_q <= prog_full_thresh;
      empty_q <= prog_empty_thresh;
    end
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  chk_full_flag: assert property (prog_full == (data_count >= full_q))
    else $error("prog_full disagrees with count");
  chk_empty_flag: assert property (prog_empty == (data_count <= empty_q))
    else $error("prog_empty disagrees with count");
  chk_count_step: assert property (!$past(rst) |-> data_count == $past(data_count)
      + CNT_W'($past(m_axi_rvalid && m_axi_rready)) - CNT_W'($past(s_axi_rvalid && s_axi_rready)))
    else $error("data_count step wrong");
  chk_valid_level: assert property (s_axi_rvalid == (clk_en && data_count != 0))
    else $error("s_axi_rvalid disagrees with count");
  chk_full_stall: assert property (m_axi_rready == (clk_en && data_count != DEPTH))
    else $error("m_axi_rready disagrees with count");
  chk_count_max: assert property (data_count <= DEPTH)
    else $error("data_count above depth");
  chk_over_low: assert property (!overflow)
    else $error("overflow raised");
  chk_under_low: assert property (!underflow)
    else $error("underflow raised");
  chk_err_offer: assert property ((sbit_err || dbit_err) |-> s_axi_rvalid && !(sbit_err && dbit_err))
    else $error("error flag without a single beat on offer");
endmodule : rcf_chk
`default_nettype wire

// *** verification/rcf_slave_model.sv ***
`default_nettype none
module rcf_slave_model (
  // Clock
  input wire logic sys_clk,
  // Fill side
  output logic [31:0] m_axi_rdata,
  output logic m_axi_rvalid,
  input wire logic m_axi_rready,
  // Error injection
  output logic [1:0] inj
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    m_axi_rvalid = 1'b0;
    m_axi_rdata = '0;
    inj = '0;
  end
  // Beat and injection stay put until the edge that takes them
  task automatic put(logic [31:0] d, logic [1:0] e);
    logic tk;
    m_axi_rvalid = 1'b1;
    m_axi_rdata = d;
    inj = e;
    do begin
      tk = m_axi_rready;
      @(posedge sys_clk);
      #2;
    end while (!tk);
  endtask : put
  // Released bus shows the inverse so stale data never passes for a beat
  task automatic idle();
    m_axi_rvalid = 1'b0;
    m_axi_rdata = ~m_axi_rdata;
    inj = '0;
  endtask : idle
endmodule : rcf_slave_model
`default_nettype wire

// *** verification/test_rcf_read_fifo.sv ***
`default_nettype none
module test_rcf_read_fifo;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, s_axi_rvalid, m_axi_rvalid, m_axi_rready, rlast, sbit_err, dbit_err;
  logic overflow, underflow, prog_full, prog_empty;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic s_axi_rready = 1'b0;
  logic [31:0] m_axi_rdata, s_axi_rdata;
  logic [3:0] s_axi_rid;
  logic [1:0] inj, rresp;
  logic [0:0] ruser;
  logic [4:0] wr_data_count, rd_data_count, data_count;
  logic [2:0] full_th = 3'h6;
  logic [2:0] empty_th = 3'h2;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  rcf_slave_model rcf_slave_model_inst (.sys_clk(sys_clk), .m_axi_rdata(m_axi_rdata),
    .m_axi_rvalid(m_axi_rvalid), .m_axi_rready(m_axi_rready), .inj(inj));
  rcf_read_fifo rcf_read_fifo_inst (.sys_clk(sys_clk), .clk_en(clk_en), .rst(rst),
    .m_axi_rid(m_axi_rdata[3:0]), .m_axi_rdata(m_axi_rdata), .m_axi_rresp(m_axi_rdata[5:4]),
    .m_axi_rlast(m_axi_rdata[6]), .m_axi_ruser(m_axi_rdata[7:7]), .m_axi_rvalid(m_axi_rvalid),
    .m_axi_rready(m_axi_rready), .s_axi_rid(s_axi_rid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(rresp), .s_axi_rlast(rlast), .s_axi_ruser(ruser), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .prog_full_thresh(full_th), .prog_empty_thresh(empty_th),
    .inject_sbit_err(inj[0]), .inject_dbit_err(inj[1]), .sbit_err(sbit_err),
    .dbit_err(dbit_err), .overflow(overflow), .underflow(underflow),
    .wr_data_count(wr_data_count), .rd_data_count(rd_data_count), .data_count(data_count),
    .prog_full(prog_full), .prog_empty(prog_empty));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic st(int n);
    chk("data_count", n, data_count);
    chk("wr_data_count", n, wr_data_count);
    chk("rd_data_count", n, rd_data_count);
    chk("prog_full", n >= full_th, prog_full);
    chk("prog_empty", n <= empty_th, prog_empty);
    chk("s_axi_rvalid", clk_en && n != 0, s_axi_rvalid);
    chk("m_axi_rready", clk_en && n != 8, m_axi_rready);
    chk("overflow", 0, overflow);
    chk("underflow", 0, underflow);
  endtask : st
  // Ready is left high so pops can run back to back
  task automatic pop(logic [31:0] d, logic [1:0] e);
    if (e != 2'h2) begin
      chk("s_axi_rdata", d, s_axi_rdata);
      chk("s_axi_rid", d[3:0], s_axi_rid);
      chk("s_axi_rresp", d[5:4], rresp);
      chk("s_axi_rlast", d[6], rlast);
      chk("s_axi_ruser", d[7], ruser);
    end
    chk("sbit_err", e == 2'h1, sbit_err);
    chk("dbit_err", e == 2'h2, dbit_err);
    s_axi_rready = 1'b1;
    @(posedge sys_clk);
    #2;
  endtask : pop
  task automatic t_reset(logic [2:0] f, logic [2:0] e);
    rst = 1'b1;
    full_th = f;
    empty_th = e;
    repeat (20) @(posedge sys_clk);
    #2;
    st(0);
    chk("sbit_err", 0, sbit_err);
    chk("dbit_err", 0, dbit_err);
    rst = 1'b0;
    $display("test reset done");
  endtask : t_reset
  task automatic t_fill();
    for (int i = 0; i < 8; i++) begin
      rcf_slave_model_inst.put(32'h5a00_0000 + i, 2'h0);
      st(i + 1);
    end
    fork
      rcf_slave_model_inst.put(32'h5a00_0008, 2'h0);
    join_none
    repeat (3) @(posedge sys_clk);
    #2;
    st(8);
    for (int i = 0; i < 9; i++) begin
      pop(32'h5a00_0000 + i, 2'h0);
      if (i == 1) rcf_slave_model_inst.idle();
      st(i == 0 ? 7 : 8 - i);
    end
    @(posedge sys_clk);
    #2;
    st(0);
    s_axi_rready = 1'b0;
    $display("test fill done");
  endtask : t_fill
  task automatic t_ecc();
    logic [31:0] d[3] = '{32'h1234_5678, 32'hcafe_0001, 32'h0bad_f00d};
    for (int i = 0; i < 3; i++) rcf_slave_model_inst.put(d[i], i[1:0]);
    rcf_slave_model_inst.idle();
    st(3);
    for (int i = 0; i < 3; i++) begin
      pop(d[i], i[1:0]);
      st(2 - i);
    end
    s_axi_rready = 1'b0;
    $display("test ecc done");
  endtask : t_ecc
  // Thresholds moved after reset must not reach the flags; a frozen block takes nothing
  task automatic t_freeze();
    rcf_slave_model_inst.put(32'h3c00_0011, 2'h0);
    rcf_slave_model_inst.idle();
    clk_en = 1'b0;
    s_axi_rready = 1'b1;
    full_th = 3'h1;
    empty_th = 3'h2;
    repeat (3) @(posedge sys_clk);
    #2;
    chk("data_count", 1, data_count);
    chk("s_axi_rvalid", 0, s_axi_rvalid);
    chk("m_axi_rready", 0, m_axi_rready);
    chk("prog_full", 0, prog_full);
    chk("prog_empty", 0, prog_empty);
    clk_en = 1'b1;
    pop(32'h3c00_0011, 2'h0);
    chk("data_count", 0, data_count);
    chk("prog_empty", 1, prog_empty);
    s_axi_rready = 1'b0;
    $display("test freeze done");
  endtask : t_freeze
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    t_reset(3'h6, 3'h2);
    t_fill();
    t_reset(3'h3, 3'h0);
    t_ecc();
    t_freeze();
    stop_test();
  end
endmodule : test_rcf_read_fifo
bind rcf_read_fifo rcf_chk #(.DEPTH(DEPTH), .TW(TW), .CNT_W(CNT_W)) rcf_chk_inst (
  .sys_clk(sys_clk), .clk_en(clk_en), .rst(rst), .m_axi_rvalid(m_axi_rvalid),
  .m_axi_rready(m_axi_rready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .prog_full_thresh(prog_full_thresh), .prog_empty_thresh(prog_empty_thresh),
  .sbit_err(sbit_err), .dbit_err(dbit_err), .overflow(overflow), .underflow(underflow),
  .data_count(data_count), .prog_full(prog_full), .prog_empty(prog_empty));
`default_nettype wire
